//--- design/mks_scanner.sv
/*
 * matrix keypad scanner: drives rows low in turn, senses columns, reports
 * the first pressed key as a scan code and serves single row reads.
 * assumes a passive switch matrix with column pull-ups and one clock.
 * assumes row_req comes from logic on clk, so it is read without syncing,
 * and that the host waits for each row answer before asking again.
 * the column lines are asynchronous and pass two flops before any use.
 * keys must stay put for about one full scan to be seen reliably.
 */
// Operation
// - drive one row low at a time, sample all columns, then next row
// - rows and columns numbered from zero, one line per logical row or column
// - scan code equals row times columns plus column plus one
// - code zero means no key; a full scan with no key gives zero
// - several keys pressed: report the first in row-major order
// - row read selects only that row, returns held-key column mask
// - report row and column counts equal to the bus widths
`timescale 1ns/1ns
`include "mks_consts.svh"

module mks_scanner (
    input wire logic clk,
    input wire logic reset,
    input mks_pkg::mks_row_req_t row_req,
    input wire logic [`MKS_COLS-1:0] col_sense_n,
    output logic [`MKS_ROWS-1:0] row_drive_n,
    output logic [`MKS_CODE_W-1:0] key_code,
    output mks_pkg::mks_row_rsp_t row_rsp,
    output mks_pkg::mks_layout_t layout
);
    import mks_pkg::*;

    // ************************************************************
    // column synchroniser
    // ************************************************************
    logic [`MKS_COLS-1:0] col_meta_reg;
    logic [`MKS_COLS-1:0] col_sync_reg;

    // two flops because the switches are asynchronous to clk
    // reset loads the idle high level so no false press follows reset
    always_ff @(posedge clk) begin
        if (reset) begin
            col_meta_reg <= {`MKS_COLS{1'b1}};
            col_sync_reg <= {`MKS_COLS{1'b1}};
        end else begin
            col_meta_reg <= col_sense_n;
            col_sync_reg <= col_meta_reg;
        end
    end

    // ************************************************************
    // scan sequencer
    // ************************************************************
    // sequencer position and row timing
    mks_state_t state_reg, state_next;
    logic [`MKS_ROW_W-1:0] row_reg, row_next;
    logic [`MKS_SETTLE_W-1:0] wait_reg, wait_next;
    logic [`MKS_ROWS-1:0] drive_reg, drive_next;
    // scan results: code of the last full scan, first hit of this one
    logic [`MKS_CODE_W-1:0] code_reg, code_next;
    logic [`MKS_CODE_W-1:0] found_reg, found_next;
    // one outstanding row read and its answer
    logic [`MKS_ROW_W-1:0] rd_row_reg, rd_row_next;
    logic pend_reg, pend_next;
    mks_row_rsp_t rsp_reg, rsp_next;
    // column decode of the row now driven
    logic [`MKS_COLS-1:0] pressed;
    logic hit;
    logic [`MKS_CODE_W-1:0] hit_code;

    // the wait covers the synchroniser flops plus wiring settle time;
    // a shorter wait would read the previous row's columns
    localparam logic [`MKS_SETTLE_W-1:0] SETTLE =
        `MKS_SETTLE_W'(`MKS_SETTLE_CYC + `MKS_SYNC_STAGES);

    // ************************************************************
    // column decode
    // ************************************************************
    // low column means pressed
    assign pressed = ~col_sync_reg;

    // lowest pressed column wins
    // scanning downwards lets the lowest column overwrite higher ones
    always_comb begin
        // defaults: no hit on this row
        hit = 1'b0;
        hit_code = '0;
        for (int c = `MKS_COLS - 1; c >= 0; c--) begin
            if (pressed[c]) begin
                hit = 1'b1;
                hit_code = `MKS_CODE_W'(row_reg * `MKS_COLS + c + 1);
            end
        end
    end

    // next-state logic; a row read is served between two row visits
    always_comb begin
        // hold everything by default; the answer is a one-cycle pulse
        state_next = state_reg;
        row_next = row_reg;
        wait_next = wait_reg;
        drive_next = drive_reg;
        code_next = code_reg;
        found_next = found_reg;
        rd_row_next = rd_row_reg;
        pend_next = pend_reg;
        rsp_next = '0;
        // take a row read only when none is open; extra ones are dropped
        if (row_req.valid && !pend_reg) begin
            pend_next = 1'b1;
            rd_row_next = row_req.row;
        end
        unique case (state_reg)
            MKS_DRIVE: begin
                // pull the next row low and start its settle wait
                // row r low alone
                drive_next = ~(`MKS_ROWS'(1) << row_reg);
                wait_next = SETTLE;
                state_next = MKS_SAMPLE;
            end
            MKS_SAMPLE: begin
                // count down the settle wait, then read the columns
                if (wait_reg != '0) begin
                    wait_next = wait_reg - 1'b1;
                end else begin
                    if (hit && found_reg == '0) begin
                        found_next = hit_code;
                    end
                    // last row: publish the scan and restart at row 0
                    if (row_reg == `MKS_ROW_W'(`MKS_ROWS - 1)) begin
                        code_next = (hit && found_reg == '0) ? hit_code : found_reg;
                        found_next = '0;
                        row_next = '0;
                    end else begin
                        row_next = row_reg + 1'b1;
                    end
                    drive_next = {`MKS_ROWS{1'b1}};
                    // a read waiting now is served before the next row visit
                    if (pend_next) begin
                        state_next = MKS_ROWRD;
                        drive_next = ~(`MKS_ROWS'(1) << rd_row_next);
                        wait_next = SETTLE;
                    end else begin
                        state_next = MKS_DRIVE;
                    end
                end
            end
            MKS_ROWRD: begin
                // host read: same settle wait as a scan visit
                if (wait_reg != '0) begin
                    wait_next = wait_reg - 1'b1;
                end else begin
                    // answer stands one cycle; rows go high again
                    // mask bit c set when held
                    rsp_next.valid = 1'b1;
                    rsp_next.cols = pressed;
                    pend_next = 1'b0;
                    drive_next = {`MKS_ROWS{1'b1}};
                    state_next = MKS_DRIVE;
                end
            end
            default: begin
                // the unused code falls back to driving
                state_next = MKS_DRIVE;
            end
        endcase
    end

    // registers of the sequencer
    // reset parks every row high so no key reads as pressed
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= MKS_DRIVE;
            row_reg <= '0;
            wait_reg <= '0;
            drive_reg <= {`MKS_ROWS{1'b1}};
            code_reg <= '0;
            found_reg <= '0;
            rd_row_reg <= '0;
            pend_reg <= 1'b0;
            rsp_reg <= '0;
        end else begin
            state_reg <= state_next;
            row_reg <= row_next;
            wait_reg <= wait_next;
            drive_reg <= drive_next;
            code_reg <= code_next;
            found_reg <= found_next;
            rd_row_reg <= rd_row_next;
            pend_reg <= pend_next;
            rsp_reg <= rsp_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    mks_layout_t layout_reg, layout_next;

    always_comb begin
        layout_next.rows = `MKS_CNT_W'(`MKS_ROWS);
        layout_next.cols = `MKS_CNT_W'(`MKS_COLS);
    end

    // the counts read zero in reset so a host can tell it is not running yet
    always_ff @(posedge clk) begin
        if (reset) begin
            layout_reg <= '0;
        end else begin
            layout_reg <= layout_next;
        end
    end

    // every output is a register, so the pins never glitch
    assign row_drive_n = drive_reg;
    assign key_code = code_reg;
    assign row_rsp = rsp_reg;
    assign layout = layout_reg;
endmodule

//--- design/mks_consts.svh
/*
 * constants for the matrix keypad scanner: matrix size, code widths, timing.
 * assumes it is included by its bare name from the package and the design.
 */
`ifndef MKS_CONSTS_SVH
`define MKS_CONSTS_SVH

// matrix layout
`define MKS_ROWS 4
`define MKS_COLS 4
`define MKS_ROW_W 2
`define MKS_CODE_W 5
`define MKS_CNT_W 8
// settle time after a row is driven, ns, and its cycle count at 4 ns per clock
`define MKS_SETTLE_NS 40
`define MKS_CLK_NS 4
`define MKS_SETTLE_CYC ((`MKS_SETTLE_NS + `MKS_CLK_NS - 1) / `MKS_CLK_NS)
`define MKS_SETTLE_W 4
// flops between a column pin and the first logic that reads it
`define MKS_SYNC_STAGES 2

`endif

//--- design/mks_pkg.sv
/*
 * types shared by the matrix keypad scanner.
 * assumes mks_consts.svh is on the include path.
 */
`include "mks_consts.svh"

package mks_pkg;
    // scanner sequencing states
    typedef enum logic [1:0] {
        MKS_DRIVE = 2'b00,
        MKS_SAMPLE = 2'b01,
        MKS_ROWRD = 2'b10
    } mks_state_t;

    // host side row read request
    typedef struct packed {
        logic valid;
        logic [`MKS_ROW_W-1:0] row;
    } mks_row_req_t;

    // host side row read answer
    typedef struct packed {
        logic valid;
        logic [`MKS_COLS-1:0] cols;
    } mks_row_rsp_t;

    // layout report
    typedef struct packed {
        logic [`MKS_CNT_W-1:0] rows;
        logic [`MKS_CNT_W-1:0] cols;
    } mks_layout_t;
endpackage

//--- bench/mks_scanner_sva.sv
/* port checker for the keypad scanner.
 * assumes one clock and a synchronous reset. */
`timescale 1ns/1ns
`include "mks_consts.svh"
// ******
// checks
// ******
module mks_scanner_sva (
    input wire logic clk,
    input wire logic reset,
    input mks_pkg::mks_row_req_t row_req,
    input wire logic [`MKS_COLS-1:0] col_sense_n,
    input wire logic [`MKS_ROWS-1:0] row_drive_n,
    input wire logic [`MKS_CODE_W-1:0] key_code,
    input mks_pkg::mks_row_rsp_t row_rsp,
    input mks_pkg::mks_layout_t layout
);
    import mks_pkg::*;
    logic pend_reg;
    logic pend_next;
    logic busy;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // open read; the scanner is free again in the cycle its answer shows,
    // so a request beside the answer pulse is taken and starts a new wait
    always_comb busy = pend_reg && !row_rsp.valid;
    always_comb pend_next = !reset && (busy || row_req.valid);
    always_ff @(posedge clk) pend_reg <= pend_next;
    property p_one_row; $countones(~row_drive_n) <= 1; endproperty
    a_one_row: assert property (p_one_row) else $error("two rows low");
    property p_row_hold; row_drive_n != 4'hF && $past(row_drive_n) == 4'hF
        |=> $stable(row_drive_n) [*8]; endproperty
    a_row_hold: assert property (p_row_hold) else $error("row visit short");
    property p_code_range; key_code <= `MKS_ROWS * `MKS_COLS; endproperty
    a_code_range: assert property (p_code_range) else $error("code range");
    property p_code_hold; $changed(key_code) |=> $stable(key_code) [*8]; endproperty
    a_code_hold: assert property (p_code_hold) else $error("code flicker");
    property p_rsp_pulse; row_rsp.valid |=> !row_rsp.valid; endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer long");
    property p_read_answer; row_req.valid && !busy |=> ##[0:30] row_rsp.valid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("no answer");
    property p_rsp_idle; row_rsp.valid |-> row_drive_n == 4'hF; endproperty
    a_rsp_idle: assert property (p_rsp_idle) else $error("row not released");
    property p_layout; !$past(reset) |-> layout.rows == `MKS_ROWS
        && layout.cols == `MKS_COLS; endproperty
    a_layout: assert property (p_layout) else $error("layout");
endmodule
bind mks_scanner mks_scanner_sva i_mks_scanner_sva (.clk(clk), .reset(reset),
    .row_req(row_req), .col_sense_n(col_sense_n), .row_drive_n(row_drive_n),
    .key_code(key_code), .row_rsp(row_rsp), .layout(layout));

//--- bench/mks_matrix_model.sv
/* passive switch matrix: a held key joins its row to its column.
 * assumes column pull-ups; keys bit r*cols+c is key (r, c). */
`timescale 1ns/1ns
`include "mks_consts.svh"
// ******
// matrix
// ******
module mks_matrix_model (
    input wire logic [`MKS_ROWS*`MKS_COLS-1:0] keys,
    input wire logic [`MKS_ROWS-1:0] row_drive_n,
    output logic [`MKS_COLS-1:0] col_sense_n
);
    // pulled high unless a held key meets a low row
    always_comb begin
        col_sense_n = '1;
        for (int r = 0; r < `MKS_ROWS; r++) begin
            col_sense_n &= ~(keys[r*`MKS_COLS +: `MKS_COLS] & {`MKS_COLS{~row_drive_n[r]}});
        end
    end
endmodule

//--- bench/tb.sv
/* bench for the keypad scanner: corner and random key patterns.
 * assumes the matrix model and the bound checker. */
`timescale 1ns/1ns
`include "mks_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
// *****
// bench
// *****
module tb;
    import mks_pkg::*;
    logic clk = 0;
    logic reset = 1;
    mks_row_req_t row_req = '0;
    logic [15:0] keys = '0;
    logic [15:0] corner [6] = '{16'h0000, 16'h0001, 16'h8000, 16'h8421, 16'h0A50,
        16'h0000};
    logic [`MKS_COLS-1:0] col_sense_n;
    logic [`MKS_ROWS-1:0] row_drive_n;
    logic [`MKS_CODE_W-1:0] key_code;
    mks_row_rsp_t row_rsp;
    mks_layout_t layout;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    mks_scanner i_mks_scanner (.clk(clk), .reset(reset), .row_req(row_req),
        .col_sense_n(col_sense_n), .row_drive_n(row_drive_n), .key_code(key_code),
        .row_rsp(row_rsp), .layout(layout));
    mks_matrix_model i_mks_matrix_model (.keys(keys), .row_drive_n(row_drive_n),
        .col_sense_n(col_sense_n));
    // first held key in row-major order, zero when none
    function automatic logic [4:0] exp_code(logic [15:0] k);
        for (int i = 0; i < 16; i++) if (k[i]) return 5'(i + 1);
        return 5'h0;
    endfunction
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // one row read; next request only after the answer
    task automatic read_row(int r, logic [15:0] k);
        @(posedge clk) row_req <= '{1'b1, 2'(r)};
        @(posedge clk) row_req <= '0;
        for (int i = 0; i < 40 && row_rsp.valid !== 1'b1; i++) @(negedge clk);
        `CHK(row_rsp.valid, 1'b1)
        `CHK(row_rsp.cols, k[r*`MKS_COLS +: `MKS_COLS])
    endtask
    // hold a pattern for over two full scans, then read every row
    task automatic apply(logic [15:0] k);
        @(posedge clk) keys <= k;
        repeat (150) @(posedge clk);
        @(negedge clk);
        `CHK(key_code, exp_code(k))
        for (int r = 0; r < `MKS_ROWS; r++) read_row(r, k);
    endtask
    initial begin
        void'($urandom(32'hADAA));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(layout, mks_layout_t'{8'(`MKS_ROWS), 8'(`MKS_COLS)})
        foreach (corner[i]) apply(corner[i]);
        repeat (6) apply(16'($urandom & $urandom & $urandom));
        tally_and_finish();
    end
    // a hang counts as a mismatch; a normal run needs about 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
endmodule
